// ===== core/btmu_pkg.sv
// constants, field layouts and types shared by the match unit files
package btmu_pkg;

    // ------------------------------------------------------------
    // register bus layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [1:0] REGION_DIRECT = 2'h0;
    localparam logic [1:0] REGION_CTRL = 2'h1;
    localparam logic [1:0] REGION_COND = 2'h2;
    localparam logic [9:0] RUN_CTRL = 10'h100;
    localparam logic [9:0] TRACE_CTRL = 10'h104;
    localparam logic [9:0] STATUS = 10'h108;
    localparam logic [9:0] PORT_VIEW = 10'h10c;
    localparam logic [2:0] WORD_CFG = 3'h0;
    localparam logic [2:0] WORD_CODE = 3'h1;
    localparam logic [2:0] WORD_PORTVAL = 3'h2;
    localparam logic [2:0] WORD_PORTCARE = 3'h3;
    localparam logic [2:0] WORD_RANGE = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // match, control and status register fields
    // ------------------------------------------------------------
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_SEL_MSB = 3;
    localparam int CFG_RANGE = 4;
    localparam int CFG_EXTERNAL_BUS_ADDRESS = 5;
    localparam logic [3:0] SEL_OPADDR = 4'h1;
    localparam logic [3:0] SEL_ALL = 4'hf;
    localparam logic [15:0] CONTENTS_MASK = 16'h00ff;
    localparam int RUN_BIT = 2;
    localparam int MODE_LSB = 2;
    localparam int ST_HALTED = 0;
    localparam int ST_OVF = 3;

    // ------------------------------------------------------------
    // frame types: bit0 contents valid, bit1 later fetch
    // ------------------------------------------------------------
    localparam int FT_CONTENTS_BIT = 0;
    localparam int FT_LATER_BIT = 1;
    localparam logic [1:0] FT_OPCODE = 2'h1;

    typedef enum logic [1:0] {
        TM_NONE,
        TM_STOP,
        TM_START,
        TM_SPARE
    } btmu_mode_e;

    typedef struct packed {
        logic [5:0] cfg;
        logic [15:0] codeVal;
        logic [15:0] codeCare;
        logic [15:0] rangeLo;
        logic [15:0] rangeHi;
        logic [23:0] portVal;
        logic [23:0] portCare;
    } btmu_mreg_s;

    localparam btmu_mreg_s MREG_RESET = '0;
    localparam logic [23:0] PORT_VIEW_RESET = 24'h000000;

endpackage

// ===== core/btmu_match_unit.sv
// one match register comparator against the current frame
`timescale 1ns/1ps
module btmu_match_unit (
    input wire logic [1:0] frameType,
    input wire logic [15:0] frameData,
    input wire logic [23:0] portsCmp,
    input wire btmu_pkg::btmu_mreg_s mreg,
    output logic hit
);
    import btmu_pkg::*;

    logic isContents;
    logic codeUsed;
    logic [3:0] typeSel;
    logic [1:0] typeIdx;
    logic [15:0] care;
    logic inRange;

    always_comb begin
        isContents = frameType[FT_CONTENTS_BIT];
        codeUsed = (mreg.codeCare != 16'h0000) || mreg.cfg[CFG_RANGE];
        // all don't-care with no type: every frame matches
        if (mreg.cfg[CFG_SEL_MSB:CFG_SEL_LSB] != 4'h0) begin
            typeSel = mreg.cfg[CFG_SEL_MSB:CFG_SEL_LSB];
        end else if (codeUsed) begin
            typeSel = SEL_OPADDR;
        end else begin
            typeSel = SEL_ALL;
        end
        // index: opcode addr, operand addr, opcode, value
        typeIdx = {frameType[FT_CONTENTS_BIT], frameType[FT_LATER_BIT]};
        // contents sit in the low byte of the code field
        care = isContents ? (mreg.codeCare & CONTENTS_MASK) : mreg.codeCare;
        if (isContents) begin
            inRange = (frameData[7:0] >= mreg.rangeLo[7:0])
                && (frameData[7:0] <= mreg.rangeHi[7:0]);
        end else begin
            inRange = (frameData >= mreg.rangeLo) && (frameData <= mreg.rangeHi);
        end
        // per-bit care covers nibble masks
        hit = typeSel[typeIdx]
            && (((frameData ^ mreg.codeVal) & care) == 16'h0000)
            && (!mreg.cfg[CFG_RANGE] || inRange)
            && (((portsCmp ^ mreg.portVal) & mreg.portCare) == 24'h000000);
    end

endmodule

// ===== core/btmu_core.sv
// breakpoint and trace qualifier match unit with its register slave
`timescale 1ns/1ps
// Function
// - trace sees port change from next opcode frame
// - reset registers match every frame
// - enable flags stored apart from conditions
// - any enabled breakpoint match halts emulation
// - plain mode collects frame after each match
// - stop mode ends trace after matching frame
// - start mode collects until buffer overflow
// - untyped code compare means opcode address
// - masked hex digit ignores four bits
// - any-address compares both address frame kinds
// - opcode and value compares are eight bits
// - last value frame catches next cycle start
// - external address is port two over zero
// - ports AND with other fields, last wins
// - condition loads any of the four and enables it
// - direct writes keep enables and controls
// - direct writes allow ranges, conditions do not
// - pair write loads both registers alike
// - pair enable lets either register act
// - frames compared twice per fetch, 42 bits
// - frame type holds two distinguishing bits
module btmu_core (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [btmu_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [btmu_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frameValid,
    input wire logic [1:0] frameType,
    input wire logic [15:0] frameData,
    input wire logic [7:0] port_zero,
    input wire logic [7:0] port_one,
    input wire logic [7:0] port_two,
    input wire logic traceBufFull,
    output logic emuRun,
    output logic haltPulse,
    output logic traceCollect
);
    import btmu_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        btmu_mreg_s [3:0] mreg;
        logic [1:0] bpEn;
        logic run;
        logic halted;
        logic haltPulse;
        logic [1:0] qEn;
        btmu_mode_e mode;
        logic traceActive;
        logic pendNext;
        logic collect;
        logic ovfStop;
        logic [23:0] portView;
        logic awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } btmu_state_s;

    btmu_state_s s;
    btmu_state_s next_s;
    logic rstMeta;
    logic rstN;
    logic [23:0] livePorts;
    logic [23:0] qualPorts;
    logic [23:0] viewNow;
    logic [3:0] hits;
    logic bpHit;
    logic qHit;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] mrRead(btmu_mreg_s m, logic [2:0] w);
        logic [31:0] r;
        r = 32'h00000000;
        if (w == WORD_CFG) begin
            r = {26'h0000000, m.cfg};
        end else if (w == WORD_CODE) begin
            r = {m.codeCare, m.codeVal};
        end else if (w == WORD_PORTVAL) begin
            r = {8'h00, m.portVal};
        end else if (w == WORD_PORTCARE) begin
            r = {8'h00, m.portCare};
        end else if (w == WORD_RANGE) begin
            r = {m.rangeHi, m.rangeLo};
        end
        return r;
    endfunction

    // only the addressed field changes, enables live elsewhere
    function automatic btmu_mreg_s mrWrite(btmu_mreg_s m, logic [2:0] w,
                                            logic [31:0] d, logic cond);
        btmu_mreg_s r;
        r = m;
        if (w == WORD_CFG) begin
            r.cfg = d[5:0];
            if (cond) begin
                r.cfg[CFG_RANGE] = 1'b0;
            end
        end else if (w == WORD_CODE) begin
            r.codeVal = d[15:0];
            r.codeCare = d[31:16];
        end else if (w == WORD_PORTVAL) begin
            r.portVal = d[23:0];
        end else if (w == WORD_PORTCARE) begin
            r.portCare = d[23:0];
        end else if (w == WORD_RANGE && !cond) begin
            r.rangeLo = d[15:0];
            r.rangeHi = d[31:16];
        end
        return r;
    endfunction

    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------
    assign livePorts = {port_two, port_one, port_zero};
    // the opcode frame itself already shows the new port values
    assign viewNow = (frameType == FT_OPCODE) ? livePorts : s.portView;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_match
            logic [23:0] cmpPorts;
            if (gi < 2) begin : g_bp
                assign cmpPorts = livePorts;
            end else begin : g_tq
                // external address pair is never delayed
                assign cmpPorts = s.mreg[gi].cfg[CFG_EXTERNAL_BUS_ADDRESS]
                    ? {livePorts[23:16], viewNow[15:8], livePorts[7:0]} : viewNow;
            end
            btmu_match_unit u_match (
                .frameType(frameType),
                .frameData(frameData),
                .portsCmp(cmpPorts),
                .mreg(s.mreg[gi]),
                .hit(hits[gi])
            );
        end
    endgenerate

    assign bpHit = frameValid && |(hits[1:0] & s.bpEn);
    assign qHit = frameValid && |(hits[3:2] & s.qEn);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] region;
        logic [2:0] word;
        logic [1:0] idx;
        logic [1:0] base;
        logic [31:0] wd;
        logic [31:0] stat;
        logic [9:0] ra;
        next_s = s;
        region = s.awAddr[9:8];
        word = s.awAddr[4:2];
        idx = s.awAddr[6:5];
        base = {s.awAddr[5], 1'b0};
        wd = 32'h00000000;
        stat = {28'h0000000, s.ovfStop, s.traceActive, s.run, s.halted};
        ra = s_axi_araddr;
        next_s.haltPulse = 1'b0;
        next_s.collect = 1'b0;

        // read channel
        if (s_axi_arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = 32'h00000000;
            next_s.rresp = RESP_OKAY;
            if ((ra[9:8] == REGION_DIRECT || ra[9:8] == REGION_COND) && !ra[7]
                && ra[4:2] <= WORD_RANGE && ra[1:0] == 2'h0) begin
                next_s.rdata = mrRead(s.mreg[ra[6:5]], ra[4:2]);
            end else if (ra[9:8] == REGION_DIRECT && ra[6] == 1'b0 && ra[1:0] == 2'h0) begin
                next_s.rdata = 32'h00000000;
            end else if (ra == RUN_CTRL) begin
                next_s.rdata = {29'h00000000, s.run, s.bpEn};
            end else if (ra == TRACE_CTRL) begin
                next_s.rdata = {28'h0000000, s.mode, s.qEn};
            end else if (ra == STATUS) begin
                next_s.rdata = stat;
            end else if (ra == PORT_VIEW) begin
                next_s.rdata = {8'h00, s.portView};
            end else begin
                next_s.rresp = RESP_SLVERR;
            end
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        // write address and data, in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.awHeld = 1'b1;
            next_s.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.wHeld = 1'b1;
            next_s.wData = s_axi_wdata;
            next_s.wStrb = s_axi_wstrb;
        end

        if (s.awHeld && s.wHeld && !s.bvalid) begin
            next_s.awHeld = 1'b0;
            next_s.wHeld = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OKAY;
            if (s.awAddr[1:0] != 2'h0 || (region != REGION_CTRL && word > WORD_RANGE)) begin
                next_s.bresp = RESP_SLVERR;
            end else if (region == REGION_DIRECT && !s.awAddr[7]) begin
                wd = merge(mrRead(s.mreg[idx], word), s.wData, s.wStrb);
                next_s.mreg[idx] = mrWrite(s.mreg[idx], word, wd, 1'b0);
            end else if (region == REGION_DIRECT && !s.awAddr[6]) begin
                // both of the pair get the same field
                wd = merge(mrRead(s.mreg[base], word), s.wData, s.wStrb);
                next_s.mreg[base] = mrWrite(s.mreg[base], word, wd, 1'b0);
                next_s.mreg[base + 2'h1] = mrWrite(s.mreg[base + 2'h1], word, wd, 1'b0);
            end else if (region == REGION_COND && !s.awAddr[7]) begin
                wd = merge(mrRead(s.mreg[idx], word), s.wData, s.wStrb);
                next_s.mreg[idx] = mrWrite(s.mreg[idx], word, wd, 1'b1);
                if (idx[1]) begin
                    next_s.qEn[idx[0]] = 1'b1;
                end else begin
                    next_s.bpEn[idx[0]] = 1'b1;
                end
            end else if (s.awAddr == RUN_CTRL) begin
                wd = merge({29'h00000000, s.run, s.bpEn}, s.wData, s.wStrb);
                next_s.bpEn = wd[1:0];
                next_s.run = wd[RUN_BIT];
            end else if (s.awAddr == TRACE_CTRL) begin
                wd = merge({28'h0000000, s.mode, s.qEn}, s.wData, s.wStrb);
                next_s.qEn = wd[1:0];
                next_s.mode = btmu_mode_e'(wd[MODE_LSB +: 2]);
                // stop mode starts collecting, start mode waits
                next_s.traceActive = (btmu_mode_e'(wd[MODE_LSB +: 2]) == TM_STOP);
                next_s.pendNext = 1'b0;
            end else if (s.awAddr == STATUS) begin
                wd = s.wData & {28'h0000000, {4{s.wStrb[0]}}};
                if (wd[ST_HALTED]) begin
                    next_s.halted = 1'b0;
                end
                if (wd[ST_OVF]) begin
                    next_s.ovfStop = 1'b0;
                end
            end else begin
                next_s.bresp = RESP_SLVERR;
            end
        end else if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // frame processing; later than the bus so frame updates win over bus writes
        if (frameValid) begin
            if (frameType == FT_OPCODE) begin
                next_s.portView = livePorts;
            end
            if (s.run && bpHit) begin
                next_s.run = 1'b0;
                next_s.halted = 1'b1;
                next_s.haltPulse = 1'b1;
            end
            if (traceBufFull) begin
                // full buffer ends start-mode collection
                next_s.traceActive = 1'b0;
                next_s.ovfStop = 1'b1;
                next_s.pendNext = 1'b0;
            end else begin
                case (s.mode)
                    TM_NONE: begin
                        // no qualifier enabled collects every frame
                        next_s.collect = s.pendNext || (s.qEn == 2'h0);
                        next_s.pendNext = qHit;
                    end
                    TM_STOP: begin
                        next_s.collect = s.traceActive;
                        if (qHit) begin
                            next_s.traceActive = 1'b0;
                        end
                    end
                    TM_START: begin
                        next_s.collect = s.traceActive;
                        if (qHit) begin
                            next_s.traceActive = 1'b1;
                        end
                    end
                    default: begin
                        next_s.collect = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            s <= '0;
            s.mreg <= {4{MREG_RESET}};
            s.mode <= TM_NONE;
            s.portView <= PORT_VIEW_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !s.awHeld && !s.bvalid;
    assign s_axi_wready = !s.wHeld && !s.bvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign emuRun = s.run;
    assign haltPulse = s.haltPulse;
    assign traceCollect = s.collect;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstN);

    a_halt_on_break: assert property (s.run && bpHit |=> haltPulse && !emuRun)
        else $error("enabled breakpoint match did not halt");
    a_halt_has_cause: assert property (haltPulse |-> $past(s.run) && $past(bpHit))
        else $error("halt without an enabled breakpoint match");
    a_reset_reg_hits: assert property (frameValid && s.mreg[0] == MREG_RESET |-> hits[0])
        else $error("reset register missed a frame");
    a_plain_next: assert property (s.mode == TM_NONE && qHit && !traceBufFull
        ##1 !frameValid
        ##1 frameValid && !traceBufFull && s.mode == TM_NONE
        |=> traceCollect)
        else $error("frame after qualifier match not collected");
    a_stop_after: assert property (s.mode == TM_STOP && s.traceActive && qHit
        && !traceBufFull |=> traceCollect && !s.traceActive)
        else $error("stop mode did not end after matching frame");
    a_start_on: assert property (s.mode == TM_START && qHit && !traceBufFull
        |=> s.traceActive)
        else $error("start mode did not switch trace on");
    a_view_lag: assert property (frameValid && frameType != FT_OPCODE
        |=> $stable(s.portView))
        else $error("port view moved off an opcode frame");
    a_direct_keeps: assert property (s.awHeld && s.wHeld && !s.bvalid
        && s.awAddr[9:8] == REGION_DIRECT |=> $stable(s.bpEn) && $stable(s.qEn)
        && $stable(s.mode))
        else $error("direct register write touched enables");
    // address is held past the write, so the next cycle still names the pair
    a_pair_equal: assert property (s.awHeld && s.wHeld && !s.bvalid
        && s.awAddr[9:8] == REGION_DIRECT && s.awAddr[7:6] == 2'h2 && s.awAddr[4:2] <= WORD_RANGE
        && s.awAddr[1:0] == 2'h0
        |=> mrRead(s.mreg[{s.awAddr[5], 1'b0}], s.awAddr[4:2])
        == mrRead(s.mreg[{s.awAddr[5], 1'b1}], s.awAddr[4:2]))
        else $error("pair write left registers different");
    a_cond_enables: assert property (s.awHeld && s.wHeld && !s.bvalid
        && s.awAddr[9:8] == REGION_COND && !s.awAddr[7] && s.awAddr[4:2] <= WORD_RANGE
        && s.awAddr[1:0] == 2'h0
        |=> (s.awAddr[6] ? s.qEn[s.awAddr[5]] : s.bpEn[s.awAddr[5]]))
        else $error("condition load did not enable register");

endmodule

// ===== tb/btmu_fetch_model.sv
// emulated microcontroller frame source for the match unit bench
`timescale 1ns/1ps
module btmu_fetch_model (
    input wire logic clk_sys,
    output logic frameValid,
    output logic [1:0] frameType,
    output logic [15:0] frameData,
    output logic [7:0] port_zero,
    output logic [7:0] port_one,
    output logic [7:0] port_two,
    output logic traceBufFull
);
    initial begin
        {frameValid, frameType, frameData, traceBufFull} = '0;
        {port_zero, port_one, port_two} = 24'h5a3c96;
    end
    // one frame per call; the bus shows a changed pattern between frames
    task automatic send(input logic [1:0] t, input logic [15:0] d);
        @(posedge clk_sys);
        frameValid <= 1'b1;
        frameType <= t;
        frameData <= d;
        @(posedge clk_sys);
        frameValid <= 1'b0;
        frameData <= ~d;
    endtask
    task automatic overflow(input logic f);
        @(posedge clk_sys);
        traceBufFull <= f;
    endtask
    task automatic ports(input logic [23:0] p);
        @(posedge clk_sys);
        {port_two, port_one, port_zero} <= p;
    endtask
endmodule

// ===== tb/breakpoint_trace_match_unit_bench.sv
// self-checking bench for the breakpoint and trace match unit
`timescale 1ns/1ps
module breakpoint_trace_match_unit_bench;
    import btmu_pkg::*;
    logic clk_sys, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, frameType, rr;
    logic [3:0] s_axi_wstrb;
    logic frameValid, traceBufFull, emuRun, haltPulse, traceCollect;
    logic [15:0] frameData;
    logic [7:0] port_zero, port_one, port_two;
    int failures, n_checks;
    btmu_core btmu_core_i (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frameValid, .frameType, .frameData,
        .port_zero, .port_one, .port_two, .traceBufFull, .emuRun, .haltPulse, .traceCollect);
    btmu_fetch_model btmu_fetch_model_i (.clk_sys, .frameValid, .frameType, .frameData,
        .port_zero, .port_one, .port_two, .traceBufFull);
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", RESP_OKAY, s_axi_bresp);
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    task automatic frm(input logic [1:0] t, input logic [15:0] d, input logic h, input logic c);
        btmu_fetch_model_i.send(t, d);
        #1;
        chk("haltPulse", h, haltPulse);
        chk("traceCollect", c, traceCollect);
    endtask
    task automatic t_break();
        rd(10'h064, rv, rr);
        chk("reset code", 32'h0, rv);
        wr(RUN_CTRL, 32'h5);
        frm(2'h3, 16'h1234, 1'b1, 1'b1);
        chk("emuRun", 32'h0, emuRun);
        wr(10'h024, 32'hff000200);
        wr(RUN_CTRL, 32'h6);
        frm(2'h2, 16'h0200, 1'b0, 1'b1);
        frm(2'h0, 16'h03ff, 1'b0, 1'b1);
        frm(2'h0, 16'h02ab, 1'b1, 1'b1);
        wr(10'h020, 32'h3);
        wr(RUN_CTRL, 32'h6);
        frm(2'h2, 16'h0211, 1'b1, 1'b1);
        $display("break test done");
    endtask
    task automatic t_regs();
        wr(RUN_CTRL, 32'h0);
        rd(10'h024, rv, rr);
        chk("kept code", 32'hff000200, rv);
        wr(RUN_CTRL, 32'h3);
        wr(10'h004, 32'h0);
        rd(RUN_CTRL, rv, rr);
        chk("enables kept", 32'h3, rv);
        wr(RUN_CTRL, 32'h0);
        wr(10'h224, 32'hffff0100);
        rd(RUN_CTRL, rv, rr);
        chk("cond enable", 32'h2, rv);
        wr(10'h084, 32'h00f00030);
        rd(10'h004, rv, rr);
        chk("pair zero", 32'h00f00030, rv);
        rd(10'h024, rv, rr);
        chk("pair one", 32'h00f00030, rv);
        rd(10'h3fc, rv, rr);
        chk("unmapped resp", RESP_SLVERR, rr);
        chk("unmapped data", 32'h0, rv);
        $display("register test done");
    endtask
    task automatic t_trace();
        wr(10'h040, 32'h8);
        wr(10'h044, 32'h00ff0055);
        wr(TRACE_CTRL, 32'h1);
        frm(2'h3, 16'h0055, 1'b0, 1'b0);
        frm(2'h0, 16'h0100, 1'b0, 1'b1);
        frm(2'h1, 16'h0055, 1'b0, 1'b0);
        frm(2'h0, 16'h0000, 1'b0, 1'b0);
        wr(TRACE_CTRL, 32'h5);
        frm(2'h0, 16'h0000, 1'b0, 1'b1);
        frm(2'h3, 16'h0055, 1'b0, 1'b1);
        frm(2'h0, 16'h0000, 1'b0, 1'b0);
        wr(TRACE_CTRL, 32'h9);
        frm(2'h0, 16'h0000, 1'b0, 1'b0);
        frm(2'h3, 16'h0055, 1'b0, 1'b0);
        frm(2'h0, 16'h0000, 1'b0, 1'b1);
        btmu_fetch_model_i.overflow(1'b1);
        frm(2'h0, 16'h0000, 1'b0, 1'b0);
        rd(STATUS, rv, rr);
        chk("status", 32'h9, rv);
        btmu_fetch_model_i.overflow(1'b0);
        $display("trace test done");
    endtask
    task automatic t_ports();
        wr(TRACE_CTRL, 32'hc);
        frm(2'h0, 16'h0000, 1'b0, 1'b0);
        wr(10'h068, 32'h1177);
        wr(10'h06c, 32'hff00);
        wr(TRACE_CTRL, 32'h2);
        btmu_fetch_model_i.ports(24'h961177);
        frm(2'h3, 16'h0000, 1'b0, 1'b0);
        frm(2'h1, 16'h0000, 1'b0, 1'b0);
        frm(2'h0, 16'h0000, 1'b0, 1'b1);
        btmu_fetch_model_i.ports(24'h9611aa);
        wr(10'h060, 32'h20);
        wr(10'h06c, 32'hff);
        frm(2'h3, 16'h0000, 1'b0, 1'b1);
        frm(2'h0, 16'h0000, 1'b0, 1'b0);
        wr(10'h050, 32'h00300010);
        wr(10'h250, 32'h0);
        rd(10'h050, rv, rr);
        chk("range kept", 32'h00300010, rv);
        $display("port test done");
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #50000;
        failures++;
        $display("mismatch watchdog expected done seen timeout");
        finish_test();
    end
    initial begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_break();
        t_regs();
        t_trace();
        t_ports();
        finish_test();
    end
endmodule
